/* alu_core.sv */
`timescale 1ns/1ps
module alu_core import alu_pkg::*; (
    // Operands
    input  wire logic [3:0] i_op,
    input  wire logic [7:0] i_acc,
    input  wire logic [7:0] i_file,
    input  wire logic       i_carry,
    // Results
    output logic      [7:0] o_result,
    output logic            o_c,
    output logic            o_nib,
    output logic            o_z,
    output logic            o_sov,
    output logic            o_arith
);
    wire logic       is_sub = (i_op == OP_SUB) || (i_op == OP_SUBB);
    // Subtract is file + ~acc + carry-in; carry out is "no borrow"
    wire logic [7:0] addend = is_sub ? ~i_acc : i_acc;
    wire logic       cin    = (i_op == OP_SUB) ? 1'b1 :
                              ((i_op == OP_ADDC) || (i_op == OP_SUBB))
                              ? i_carry : 1'b0;
    wire logic [4:0] low    = {1'b0, i_file[3:0]} + {1'b0, addend[3:0]}
                              + {4'h0, cin};
    wire logic [3:0] hi6    = {1'b0, i_file[6:4]} + {1'b0, addend[6:4]}
                              + {3'h0, low[4]};
    wire logic [1:0] top    = {1'b0, i_file[7]} + {1'b0, addend[7]}
                              + {1'b0, hi6[3]};
    wire logic [7:0] sum    = {top[0], hi6[2:0], low[3:0]};

    always_comb begin
        o_result = sum;
        o_c      = top[1];
        o_nib    = low[4];
        o_sov    = top[1] ^ hi6[3];
        o_arith  = 1'b1;
        case (i_op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
                o_arith = 1'b1;
            end
            OP_AND: begin
                o_result = i_acc & i_file;
                o_arith  = 1'b0;
            end
            OP_IOR: begin
                o_result = i_acc | i_file;
                o_arith  = 1'b0;
            end
            OP_XOR: begin
                o_result = i_acc ^ i_file;
                o_arith  = 1'b0;
            end
            OP_RLC: begin
                o_result = {i_file[6:0], i_carry};
                o_c      = i_file[7];
                o_arith  = 1'b0;
            end
            OP_RRC: begin
                o_result = {i_carry, i_file[7:1]};
                o_c      = i_file[0];
                o_arith  = 1'b0;
            end
            default: begin
                o_result = i_file;
                o_arith  = 1'b0;
            end
        endcase
        o_z = (o_result == RST_BYTE);
    end
endmodule

/* alu_datapath.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - 8-bit unit adds, subtracts, shifts, logic between accumulator and file
// - Arithmetic is two's complement
// - Instructions update carry, nibble carry, zero, overflow in status
// - Subtraction uses carry and nibble carry as inverted borrow-out bits (set means no borrow)
// - Overflow set when signed result leaves the range -128..127
// - Overflow is the XOR of the carries out of bits six and seven
// - Unsigned 8x8 multiplier gives 16-bit product in one cycle
// - Some instructions move file to file without the accumulator
// - 16-bit instruction word fetched over its own bus in one cycle
// - Fetch and execute overlap; branches and table moves take two
// - Program address space covers 64K words of 16 bits
// - Internal, external or mixed execution; no protection when mixed
// - Counter and accumulator are readable like file registers
// - Cycle rate is oscillator over four, driven on clock output
module alu_datapath import alu_pkg::*; (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // AXI4-Lite write address and data
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    // AXI4-Lite write response
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic      [1:0]  o_bresp,
    // AXI4-Lite read
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic      [31:0] o_rdata,
    output logic      [1:0]  o_rresp,
    // Pins
    output logic             o_cycle_rate_output,
    output logic             o_irq
);
    logic [7:0]  working_accumulator_ff;
    logic [7:0]  file_a_ff;
    logic [7:0]  operand_ff;
    logic [3:0]  arith_status_register_ff;
    logic [15:0] product_ff;
    logic [15:0] program_counter_ff;
    logic [15:0] instr_ff;
    logic [2:0]  irq_st_ff;
    logic [2:0]  irq_msk_ff;
    logic [1:0]  mode_ff;
    logic [11:0] ctrl_ff;
    logic        aw_ff, w_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic [1:0]  div_ff;
    logic        clkout_ff;
    logic        irq_ff;
    pipe_state_t state_ff;

    // Execution engine inputs/outputs
    wire logic [3:0]  op     = ctrl_ff[CTL_OP_LSB +: 4];
    wire logic        to_acc = ~ctrl_ff[CTL_DST_BIT];
    wire logic [7:0]  res;
    wire logic        f_c, f_nib, f_z, f_sov, f_arith;
    wire logic [15:0] prod;

    alu_core u_alu (
        .i_op     (op),
        .i_acc    (working_accumulator_ff),
        .i_file   (operand_ff),
        .i_carry  (arith_status_register_ff[FLG_C]),
        .o_result (res),
        .o_c      (f_c),
        .o_nib    (f_nib),
        .o_z      (f_z),
        .o_sov    (f_sov),
        .o_arith  (f_arith)
    );

    mul8x8 u_mul (
        .i_a    (working_accumulator_ff),
        .i_b    (operand_ff),
        .o_prod (prod)
    );

    // Bus decode
    wire logic       wr_go  = aw_ff && w_ff && !o_bvalid;
    wire logic       rd_go  = i_arvalid && o_arready;
    // Ready flops follow the next state of the capture and response flags
    wire logic       nxt_aw = !wr_go && (aw_ff || (i_awvalid && o_awready));
    wire logic       nxt_w  = !wr_go && (w_ff || (i_wvalid && o_wready));
    wire logic       nxt_bv = wr_go || (o_bvalid && !i_bready);
    wire logic       nxt_rv = rd_go || (o_rvalid && !i_rready);
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= OFF_INSTR);
    endfunction
    wire logic       wr_ok  = is_mapped(awaddr_ff);
    wire logic       go_wr  = wr_go && wr_ok && (awaddr_ff == OFF_CTRL)
                              && wstrb_ff[1] && wdata_ff[CTL_GO_BIT];
    wire logic       is_long = (op == OP_BRA) || (op == OP_TBL);
    wire logic       exec   = (state_ff == ST_EXEC);
    wire logic       finish = exec || (state_ff == ST_WAIT);
    wire logic       done_ev = (state_ff == ST_WAIT) || (exec && !is_long);
    wire logic       retire = exec && !is_long;
    wire logic       flag_wr = retire && (op != OP_MUL) && (op != OP_MOVF);
    wire logic [2:0] events = {retire && f_arith && f_c,
                               retire && f_arith && f_sov,
                               done_ev};
    wire logic [2:0] w1c    = (wr_go && wr_ok && awaddr_ff == OFF_IRQ_ST
                              && wstrb_ff[0]) ? wdata_ff[2:0] : 3'h0;
    // Protection is meaningless in mixed mode; that code is stored unchanged, like the others
    wire logic [1:0] mode_in = (wdata_ff[1:0] == MODE_MIX) ? MODE_MIX
                               : wdata_ff[1:0];

    logic [31:0] rd_mux;
    always_comb begin
        case (i_araddr)
            OFF_CTRL:    rd_mux = {20'h00000, ctrl_ff};
            OFF_OPERAND: rd_mux = {24'h000000, operand_ff};
            OFF_WACC:    rd_mux = {24'h0, working_accumulator_ff};
            OFF_STATUS:  rd_mux = {28'h0000000, arith_status_register_ff};
            OFF_PRODUCT: rd_mux = {16'h0000, product_ff};
            OFF_IRQ_ST:  rd_mux = {29'h00000000, irq_st_ff};
            OFF_IRQ_MSK: rd_mux = {29'h00000000, irq_msk_ff};
            OFF_FILE_A:  rd_mux = {24'h000000, file_a_ff};
            OFF_MODE:    rd_mux = {30'h00000000, mode_ff};
            OFF_PCOUNT:  rd_mux = {16'h0000, program_counter_ff};
            OFF_INSTR:   rd_mux = {16'h0000, instr_ff};
            default:     rd_mux = 32'h00000000;
        endcase
    end

    // Write channel acceptance, either order
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_ff <= 1'b0;
            w_ff  <= 1'b0;
            awaddr_ff <= RST_BYTE;
            wdata_ff  <= 32'h00000000;
            wstrb_ff  <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OK;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (wr_go) begin
                aw_ff    <= 1'b0;
                w_ff     <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= wr_ok ? RESP_OK : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            o_awready <= !nxt_aw && !nxt_bv;
            o_wready  <= !nxt_w && !nxt_bv;
        end
    end

    // Read channel: one cycle to answer
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h00000000;
            o_rresp  <= RESP_OK;
            o_arready <= 1'b1;
        end else begin
            o_arready <= !nxt_rv;
            if (rd_go) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_mux;
                o_rresp  <= is_mapped(i_araddr) ? RESP_OK : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Pipeline: go loads execute stage, long ops spend a wait cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: if (go_wr) state_ff <= ST_EXEC;
                ST_EXEC: state_ff <= is_long ? ST_WAIT : ST_IDLE;
                ST_WAIT: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Software registers and execute results
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_ff    <= 12'h000;
            operand_ff <= RST_BYTE;
            working_accumulator_ff <= RST_BYTE;
            file_a_ff  <= RST_BYTE;
            arith_status_register_ff <= 4'h0;
            product_ff <= RST_WORD;
            program_counter_ff <= RST_WORD;
            instr_ff   <= RST_WORD;
            irq_msk_ff <= 3'h0;
            mode_ff    <= RST_MODE;
        end else begin
            if (wr_go && wr_ok && wstrb_ff[0] && !finish) begin
                case (awaddr_ff)
                    OFF_CTRL:    ctrl_ff <= {wdata_ff[11:9], 1'b0,
                                             wdata_ff[7:0]};
                    OFF_OPERAND: operand_ff <= wdata_ff[7:0];
                    OFF_WACC:    working_accumulator_ff <= wdata_ff[7:0];
                    OFF_FILE_A:  file_a_ff <= wdata_ff[7:0];
                    OFF_IRQ_MSK: irq_msk_ff <= wdata_ff[2:0];
                    OFF_MODE:    mode_ff <= mode_in;
                    OFF_INSTR:   instr_ff <= wdata_ff[15:0];
                    default:     ;
                endcase
            end
            if (retire) begin
                program_counter_ff <= program_counter_ff + 16'h0001;
                if (op == OP_MUL) begin
                    product_ff <= prod;
                end else if (op == OP_MOVF) begin
                    file_a_ff <= operand_ff;
                end else if (to_acc) begin
                    working_accumulator_ff <= res;
                end else begin
                    file_a_ff <= res;
                end
            end
            if (flag_wr) begin
                arith_status_register_ff[FLG_Z] <= f_z;
                if (f_arith) begin
                    arith_status_register_ff[FLG_NIB] <= f_nib;
                    arith_status_register_ff[FLG_SOV] <= f_sov;
                end
                if (f_arith || op == OP_RLC || op == OP_RRC) begin
                    arith_status_register_ff[FLG_C] <= f_c;
                end
            end
            if (state_ff == ST_WAIT && op == OP_BRA) begin
                program_counter_ff <= instr_ff;
            end else if (state_ff == ST_WAIT) begin
                program_counter_ff <= program_counter_ff + 16'h0001;
            end
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            irq_st_ff <= 3'h0;
            irq_ff    <= 1'b0;
        end else begin
            irq_st_ff <= (irq_st_ff & ~w1c) | events;
            irq_ff    <= |(((irq_st_ff & ~w1c) | events) & irq_msk_ff);
        end
    end
    assign o_irq = irq_ff;

    // Instruction cycle clock out: toggles every two system clocks
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            div_ff    <= 2'h0;
            clkout_ff <= 1'b0;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (div_ff == DIV_LAST) begin
                div_ff    <= 2'h0;
                clkout_ff <= ~clkout_ff;
            end
        end
    end
    assign o_cycle_rate_output = clkout_ff;

    alu_sum_a: assert property (@(posedge i_clock) disable iff (i_rst)
        retire && op == OP_ADD && to_acc |=> working_accumulator_ff ==
        8'($past(operand_ff) + $past(working_accumulator_ff)))
        else $error("add result wrong");
    sub_carry_a: assert property (@(posedge i_clock) disable iff (i_rst)
        retire && op == OP_SUB |=> arith_status_register_ff[FLG_C] ==
        ($past(operand_ff) >= $past(working_accumulator_ff)))
        else $error("borrow polarity wrong");
    // Plain 8-bit sum, independent of the destination of the result
    wire logic [7:0] add_chk = operand_ff + working_accumulator_ff;
    ovf_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
        retire && op == OP_ADD |=> arith_status_register_ff[FLG_SOV] ==
        $past((operand_ff[7] == working_accumulator_ff[7]) &&
              (add_chk[7] != operand_ff[7])))
        else $error("overflow wrong");
    zero_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
        flag_wr |=> arith_status_register_ff[FLG_Z] == $past(f_z))
        else $error("zero flag wrong");
    mul_prod_a: assert property (@(posedge i_clock) disable iff (i_rst)
        retire && op == OP_MUL |=> product_ff ==
        16'($past(operand_ff) * $past(working_accumulator_ff)))
        else $error("product wrong");
    long_op_a: assert property (@(posedge i_clock) disable iff (i_rst)
        exec && is_long |=> state_ff == ST_WAIT ##1 state_ff == ST_IDLE)
        else $error("two cycle op wrong");
    short_op_a: assert property (@(posedge i_clock) disable iff (i_rst)
        exec && !is_long |=> state_ff == ST_IDLE)
        else $error("single cycle op wrong");
    clk_out_a: assert property (@(posedge i_clock) disable iff (i_rst)
        $changed(clkout_ff) |=> $stable(clkout_ff) ##1 $changed(clkout_ff))
        else $error("cycle rate output wrong");
    move_file_a: assert property (@(posedge i_clock) disable iff (i_rst)
        retire && op == OP_MOVF |=> file_a_ff == $past(operand_ff) &&
        $stable(working_accumulator_ff))
        else $error("file move wrong");
endmodule

/* alu_pkg.sv */
package alu_pkg;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_OPERAND = 8'h04;
    localparam logic [7:0] OFF_WACC    = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_PRODUCT = 8'h10;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h14;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
    localparam logic [7:0] OFF_FILE_A  = 8'h1C;
    localparam logic [7:0] OFF_MODE    = 8'h20;
    localparam logic [7:0] OFF_PCOUNT  = 8'h24;
    localparam logic [7:0] OFF_INSTR   = 8'h28;
    // Flag bit positions in the arith status register
    localparam int FLG_C   = 0;
    localparam int FLG_NIB = 1;
    localparam int FLG_Z   = 2;
    localparam int FLG_SOV = 3;
    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVF  = 1;
    localparam int IRQ_CRY  = 2;
    // Control register fields
    localparam int CTL_OP_LSB  = 0;
    localparam int CTL_DST_BIT = 4;
    localparam int CTL_GO_BIT  = 8;
    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0]  RST_MODE = 2'h0;
    // Two-cycle instructions: branch and program/data transfers
    localparam logic [1:0]  LONG_OPS = 2'h2;
    localparam logic [1:0]  RESP_OK     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  DIV_LAST = 2'h1;

    typedef enum logic [3:0] {
        OP_ADD  = 4'h0, OP_ADDC = 4'h1, OP_SUB  = 4'h2, OP_SUBB = 4'h3,
        OP_AND  = 4'h4, OP_IOR  = 4'h5, OP_XOR  = 4'h6, OP_RLC  = 4'h7,
        OP_RRC  = 4'h8, OP_MUL  = 4'h9, OP_MOVF = 4'hA, OP_BRA  = 4'hB,
        OP_TBL  = 4'hC
    } alu_op_t;

    typedef enum logic [1:0] {
        MODE_INT = 2'h0, MODE_PROT = 2'h1, MODE_EXT = 2'h2, MODE_MIX = 2'h3
    } exec_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_WAIT = 2'b11
    } pipe_state_t;
endpackage

/* eight_bit_alu_status_flags_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module eight_bit_alu_status_flags_bench import alu_pkg::*;;
    localparam int LIMIT = 20000;
    // Bench stimulus
    logic        i_clock   = 1'b0;
    logic        i_rst     = 1'b1;
    logic        i_awvalid = 1'b0;
    logic [7:0]  i_awaddr  = 8'h00;
    logic        i_wvalid  = 1'b0;
    logic [31:0] i_wdata   = 32'h0000_0000;
    logic [3:0]  i_wstrb   = 4'h0;
    logic        i_bready  = 1'b0;
    logic        i_arvalid = 1'b0;
    logic [7:0]  i_araddr  = 8'h00;
    logic        i_rready  = 1'b0;
    // Design answers
    logic        o_awready;
    logic        o_wready;
    logic        o_bvalid;
    logic [1:0]  o_bresp;
    logic        o_arready;
    logic        o_rvalid;
    logic [31:0] o_rdata;
    logic [1:0]  o_rresp;
    logic        o_cycle_rate_output;
    logic        o_irq;
    int          fails   = 0;
    int          n_tests = 0;
    int          cycles  = 0;

    alu_datapath DUT (
        .i_clock(i_clock), .i_rst(i_rst),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_cycle_rate_output(o_cycle_rate_output), .o_irq(o_irq)
    );

    always #50 i_clock = ~i_clock;

    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic aw_done;
        logic w_done;
        logic aw_hit;
        logic w_hit;
        logic hit;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge i_clock);
        i_awvalid <= 1'b1;
        i_awaddr  <= a;
        i_wvalid  <= 1'b1;
        i_wdata   <= d;
        i_wstrb   <= 4'hF;
        i_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge i_clock);
            aw_hit = i_awvalid && o_awready;
            w_hit  = i_wvalid && o_wready;
            @(posedge i_clock);
            if (aw_hit) begin
                i_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_hit) begin
                i_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do begin
            @(negedge i_clock);
            hit = o_bvalid;
            r   = o_bresp;
            @(posedge i_clock);
        end while (!hit);
        i_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic hit;
        @(posedge i_clock);
        i_arvalid <= 1'b1;
        i_araddr  <= a;
        i_rready  <= 1'b1;
        do begin
            @(negedge i_clock);
            hit = o_arready;
            @(posedge i_clock);
        end while (!hit);
        i_arvalid <= 1'b0;
        do begin
            @(negedge i_clock);
            hit = o_rvalid;
            d   = o_rdata;
            r   = o_rresp;
            @(posedge i_clock);
        end while (!hit);
        i_rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        `CHK(r, RESP_OK)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] msk);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        `CHK(d & msk, e)
    endtask

    // Launch an operation and let it retire before the next access
    task automatic go(input logic [3:0] op, input logic dst);
        wr(OFF_CTRL, {23'h0, 1'b1, 3'h0, dst, op});
        repeat (4) @(posedge i_clock);
    endtask

    function automatic logic [31:0] fl(input logic c, nib, z, sov);
        fl          = 32'h0000_0000;
        fl[FLG_C]   = c;
        fl[FLG_NIB] = nib;
        fl[FLG_Z]   = z;
        fl[FLG_SOV] = sov;
    endfunction

    task automatic arith(input logic [3:0] op, input logic [7:0] acc, opd,
                         res, input logic [31:0] st, msk);
        wr(OFF_WACC, {24'h0, acc});
        wr(OFF_OPERAND, {24'h0, opd});
        go(op, 1'b0);
        rd_chk(OFF_WACC, {24'h0, res}, 32'hFFFF_FFFF);
        rd_chk(OFF_STATUS, st, msk);
    endtask

    task automatic t_reset_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(OFF_STATUS, 32'h0, 32'hFFFF_FFFF);
        rd_chk(OFF_PCOUNT, 32'h0, 32'hFFFF_FFFF);
        rd_chk(OFF_PRODUCT, 32'h0, 32'hFFFF_FFFF);
        axi_rd(8'h40, d, r);
        `CHK({d, r}, {32'h0, RESP_SLVERR})
        axi_rd(8'h05, d, r);
        `CHK(r, RESP_SLVERR)
        axi_wr(8'h40, 32'h0000_00FF, r);
        `CHK(r, RESP_SLVERR)
        $display("test reset_unmapped done");
    endtask

    task automatic t_add_sub;
        arith(OP_ADD, 8'hFF, 8'h01, 8'h00, fl(1, 1, 1, 0), 32'hF);
        arith(OP_ADD, 8'h7F, 8'h01, 8'h80, fl(0, 1, 0, 1), 32'hF);
        arith(OP_ADD, 8'h80, 8'h80, 8'h00, fl(1, 0, 1, 1), 32'hF);
        arith(OP_ADD, 8'h40, 8'h40, 8'h80, fl(0, 0, 0, 1), 32'hF);
        arith(OP_ADD, 8'hC0, 8'hC0, 8'h80, fl(1, 0, 0, 0), 32'hF);
        arith(OP_SUB, 8'h03, 8'h05, 8'h02, fl(1, 1, 0, 0), 32'hF);
        arith(OP_SUB, 8'h05, 8'h03, 8'hFE, fl(0, 0, 0, 0), 32'hF);
        arith(OP_SUB, 8'h01, 8'h80, 8'h7F, fl(1, 0, 0, 1), 32'hF);
        arith(OP_SUB, 8'h5A, 8'h5A, 8'h00, fl(1, 1, 1, 0), 32'hF);
        // Carry left set by the previous subtraction feeds this add
        arith(OP_ADDC, 8'h01, 8'h01, 8'h03, fl(0, 0, 0, 0), 32'hF);
        $display("test add_sub done");
    endtask

    task automatic t_logic_mul_move;
        arith(OP_AND, 8'hF0, 8'h3C, 8'h30, 32'h0, 32'h4);
        arith(OP_XOR, 8'hF0, 8'hF0, 8'h00, 32'h4, 32'h4);
        arith(OP_IOR, 8'h0F, 8'hF0, 8'hFF, 32'h0, 32'h4);
        // RLC runs through the carry left clear by the last add, RRC through the carry RLC set
        arith(OP_RLC, 8'h00, 8'h81, 8'h02, fl(1, 0, 0, 0), 32'h5);
        arith(OP_RRC, 8'h00, 8'h02, 8'h81, fl(0, 0, 0, 0), 32'h5);
        arith(OP_SUBB, 8'h03, 8'h05, 8'h01, fl(1, 1, 0, 0), 32'hF);
        wr(OFF_WACC, 32'h0000_00FF);
        wr(OFF_OPERAND, 32'h0000_00FF);
        go(OP_MUL, 1'b0);
        rd_chk(OFF_PRODUCT, 32'h0000_FE01, 32'hFFFF_FFFF);
        wr(OFF_WACC, 32'h0000_0033);
        wr(OFF_OPERAND, 32'h0000_00A5);
        go(OP_MOVF, 1'b1);
        rd_chk(OFF_FILE_A, 32'h0000_00A5, 32'hFFFF_FFFF);
        rd_chk(OFF_WACC, 32'h0000_0033, 32'hFFFF_FFFF);
        $display("test logic_mul_move done");
    endtask

    task automatic t_pc_mode;
        logic [31:0] p;
        logic [1:0]  r;
        axi_rd(OFF_PCOUNT, p, r);
        go(OP_ADD, 1'b0);
        rd_chk(OFF_PCOUNT, (p + 32'h1) & 32'hFFFF, 32'hFFFF_FFFF);
        wr(OFF_INSTR, 32'h0000_FFFF);
        go(OP_BRA, 1'b0);
        rd_chk(OFF_PCOUNT, 32'h0000_FFFF, 32'hFFFF_FFFF);
        go(OP_ADD, 1'b0);
        rd_chk(OFF_PCOUNT, 32'h0000_0000, 32'hFFFF_FFFF);
        go(OP_TBL, 1'b0);
        rd_chk(OFF_PCOUNT, 32'h0000_0001, 32'hFFFF_FFFF);
        for (int m = 0; m < 4; m++) begin
            wr(OFF_MODE, m);
            rd_chk(OFF_MODE, m, 32'hFFFF_FFFF);
        end
        $display("test pc_mode done");
    endtask

    task automatic t_irq_clk;
        int rises;
        int highs;
        logic last;
        wr(OFF_IRQ_MSK, 32'h0);
        wr(OFF_IRQ_ST, 32'h0000_00FF);
        arith(OP_ADD, 8'hFF, 8'h01, 8'h00, fl(1, 1, 1, 0), 32'hF);
        rd_chk(OFF_IRQ_ST, (32'h1 << IRQ_DONE) | (32'h1 << IRQ_CRY),
               32'hFFFF_FFFF);
        `CHK(o_irq, 1'b0)
        wr(OFF_IRQ_MSK, 32'h1 << IRQ_DONE);
        repeat (2) @(negedge i_clock);
        `CHK(o_irq, 1'b1)
        wr(OFF_IRQ_ST, 32'h1 << IRQ_DONE);
        repeat (2) @(negedge i_clock);
        `CHK(o_irq, 1'b0)
        rd_chk(OFF_IRQ_ST, 32'h1 << IRQ_CRY, 32'hFFFF_FFFF);
        rises = 0;
        highs = 0;
        @(negedge i_clock);
        last = o_cycle_rate_output;
        repeat (40) begin
            @(negedge i_clock);
            if (o_cycle_rate_output === 1'b1 && last === 1'b0) rises++;
            if (o_cycle_rate_output === 1'b1) highs++;
            last = o_cycle_rate_output;
        end
        `CHK(rises, 10)
        `CHK(highs, 20)
        $display("test irq_clk done");
    endtask

    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset_unmapped();
        t_add_sub();
        t_logic_mul_move();
        t_pc_mode();
        t_irq_clk();
        finish_test();
    end
endmodule

/* mul8x8.sv */
`timescale 1ns/1ps
module mul8x8 import alu_pkg::*; (
    // Factors
    input  wire logic [7:0]  i_a,
    input  wire logic [7:0]  i_b,
    // Product
    output logic      [15:0] o_prod
);
    // Unsigned, purely combinational: ready in the same cycle
    assign o_prod = {8'h00, i_a} * {8'h00, i_b};
endmodule
